/* File: hdl/sbrg_edge_sync.sv */
// Two-stage synchroniser and rising edge detector for the pin clock
`timescale 1ns/1ps
module sbrg_edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output logic      rise
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic rise_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      rise_reg <= s2_reg & ~s3_reg; // R18
    end
  end

  assign rise = rise_reg;

  ext_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    rise_reg |=> !rise_reg)
    else $error("pin edge gave more than one pulse");

endmodule

/* File: hdl/sbrg_prescaler.sv */
// Fixed divider of the master clock, one pulse per period
`timescale 1ns/1ps
module sbrg_prescaler
  import sbrg_pkg::*;
#(
  parameter int unsigned DIV = PRESC_DIV
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  output logic      tick
);

  logic [7:0] cnt_reg;
  logic       tick_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else if (run) begin
      if (cnt_reg == 8'(DIV - 1)) begin
        cnt_reg  <= 8'h00;
        tick_reg <= 1'b1;
      end else begin
        cnt_reg  <= cnt_reg + 8'h01;
        tick_reg <= 1'b0;
      end
    end else begin
      // Frozen while gated, count kept
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

  presc_gap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R02
    tick_reg |=> !tick_reg [*7])
    else $error("prescaler pulses closer than eight cycles");

endmodule

/* File: hdl/sbrg_top.sv */
// Baud rate generator with its AHB-Lite register slave
// Behaviour
// [R01] One bit clock feeds receiver and transmitter
// [R02] Source: master clock, clock/8, pin
// [R03] Sixteen-bit integer divisor from config register
// [R04] Divisor zero stops all output ticks; code still passes sync pin clock ticks to the bit clock
// [R05] Divisor one bypasses the integer divider
// [R06] Pin clock levels exceed one master period
// [R07] Pin clock at most master/4.5 or /6
// [R08] Async: divided clock samples, then /16 or /8
// [R09] Oversample bit picks eight, else sixteen
// [R10] Nonzero fraction adds eighth steps to divisor
// [R11] Fraction only in normal async mode
// [R12] Gated clock freezes state, resumes unchanged
// [R13] Config writes accepted while clock gated
// [R14] Interrupt line sensed as a level
// [R15] Software keeps bit-rate error within 5%
// [R16] Sync: divisor only; pin clock undivided
// [R17] Master-clock source keeps 50:50 serial clock
// [R18] Pin clock synchronised, edges detected first
`timescale 1ns/1ps
module sbrg_top
  import sbrg_pkg::*;
#(
  parameter int unsigned PRESC = PRESC_DIV
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        periph_clk_en,
  input  wire logic        ext_clk_in,
  output logic             baud_tick,
  output logic             sample_tick,
  output logic             sck_out,
  output logic             sck_oe
);

  sbrg_cfg_t        cfg_reg;
  logic             wr_pend_reg;
  logic [11:0]      wr_ofs_reg;
  logic [31:0]      hrdata_reg;
  logic             hreadyout_reg;
  logic             hresp_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [FP_W-1:0]  acc_reg;
  logic [3:0]       os_cnt_reg;
  logic             baud_tick_reg;
  logic             sample_tick_reg;
  logic             sck_pos_reg;
  logic             sck_neg_reg;
  logic             sck_oe_reg;

  logic             addr_ok;
  logic             run;
  logic             presc_tick;
  logic             ext_tick;
  logic             src_tick;
  logic             div_tick;
  logic             frac_on;
  logic [FP_W:0]    frac_sum;
  logic [DIV_W-1:0] reload;
  logic [DIV_W-1:0] half_mark;
  logic [3:0]       os_last;
  logic             baud_next;
  logic             sample_next;
  logic             pos_toggle;
  logic             neg_toggle;
  logic [31:0]      rd_val;

  // Power manager gate; no clock is actually stopped so state holds
  assign run = periph_clk_en;

  sbrg_prescaler #(
    .DIV (PRESC)
  ) u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (run),
    .tick    (presc_tick)
  );

  sbrg_edge_sync u_ext (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (ext_clk_in),
    .rise    (ext_tick)
  );

  // Bus slave, zero wait states
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      wr_ofs_reg  <= haddr[11:0];
    end
  end

  // Write path ignores the gate so software can configure first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg.op_mode    <= MODE_RST[OPM_LSB +: 4];
      cfg_reg.clk_out_en <= MODE_RST[CLKO_BIT];
      cfg_reg.src        <= sbrg_src_t'(MODE_RST[SRC_LSB +: 2]);
      cfg_reg.over8      <= MODE_RST[OVER_BIT];
      cfg_reg.sync       <= MODE_RST[SYNC_BIT];
      cfg_reg.frac       <= DIVCFG_RST[FP_LSB +: FP_W];
      cfg_reg.div        <= DIVCFG_RST[DIV_LSB +: DIV_W];
    end else if (wr_pend_reg) begin // R13
      if (wr_ofs_reg == MODE_OFS) begin
        cfg_reg.op_mode    <= hwdata[OPM_LSB +: 4];
        cfg_reg.clk_out_en <= hwdata[CLKO_BIT];
        cfg_reg.src        <= sbrg_src_t'(hwdata[SRC_LSB +: 2]); // R02
        cfg_reg.over8      <= hwdata[OVER_BIT]; // R09
        cfg_reg.sync       <= hwdata[SYNC_BIT];
      end else if (wr_ofs_reg == DIVCFG_OFS) begin
        cfg_reg.frac <= hwdata[FP_LSB +: FP_W];
        cfg_reg.div  <= hwdata[DIV_LSB +: DIV_W]; // R03
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[11:0] == MODE_OFS) begin
      rd_val[OPM_LSB +: 4]  = cfg_reg.op_mode;
      rd_val[CLKO_BIT]      = cfg_reg.clk_out_en;
      rd_val[SRC_LSB +: 2]  = cfg_reg.src;
      rd_val[OVER_BIT]      = cfg_reg.over8;
      rd_val[SYNC_BIT]      = cfg_reg.sync;
    end else if (haddr[11:0] == DIVCFG_OFS) begin
      rd_val[FP_LSB +: FP_W]   = cfg_reg.frac;
      rd_val[DIV_LSB +: DIV_W] = cfg_reg.div;
    end else if (haddr[11:0] == STATUS_OFS) begin
      rd_val[DIV_W-1:0]      = cnt_reg;
      rd_val[ST_RUN_BIT]     = run;
      rd_val[ST_OS_LSB +: 4] = os_cnt_reg;
    end
  end

  // Read data sampled at the address phase, held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      hrdata_reg    <= (addr_ok & ~hwrite) ? rd_val : 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  // Source selection
  always_comb begin
    unique case (cfg_reg.src)
      SBRG_SRC_MCK:  src_tick = 1'b1; // R02
      SBRG_SRC_DIV:  src_tick = presc_tick;
      SBRG_SRC_EXT:  src_tick = ext_tick; // R18
      SBRG_SRC_RSVD: src_tick = 1'b0;
    endcase
  end

  // Fraction stretches one period in eight per unit of fraction
  assign frac_on  = (cfg_reg.frac != 3'h0) & ~cfg_reg.sync &
                    (cfg_reg.op_mode == OPM_NORMAL); // R11
  assign frac_sum = {1'b0, acc_reg} + {1'b0, cfg_reg.frac}; // R10
  assign reload   = cfg_reg.div - 16'h0001 +
                    {15'h0000, frac_on & frac_sum[FP_W]}; // R10
  // Count that stands half a period after reload; odd lands mid-cycle
  assign half_mark = cfg_reg.div >> 1; // R17

  assign div_tick = run & src_tick &
                    ((cfg_reg.div == 16'h0001) | // R05
                     ((cfg_reg.div > 16'h0001) & (cnt_reg == 16'h0000)));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
      acc_reg <= 3'h0;
    end else if (!run) begin
      cnt_reg <= cnt_reg; // R12
      acc_reg <= acc_reg;
    end else if (cfg_reg.div == 16'h0000) begin // R04
      cnt_reg <= 16'h0000;
      acc_reg <= 3'h0;
    end else if (src_tick) begin
      if (cnt_reg == 16'h0000) begin
        cnt_reg <= reload; // R03
        if (frac_on) begin
          acc_reg <= frac_sum[FP_W-1:0];
        end
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // Oversampling stage of asynchronous mode
  assign os_last = cfg_reg.over8 ? OVS8_LAST : OVS16_LAST; // R09

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      os_cnt_reg <= 4'h0;
    end else if (run & cfg_reg.sync) begin
      os_cnt_reg <= 4'h0;
    end else if (div_tick) begin // R08
      os_cnt_reg <= (os_cnt_reg >= os_last) ? 4'h0 : os_cnt_reg + 4'h1;
    end
  end

  // External pin in sync mode bypasses the divisor, even when zero
  always_comb begin
    if (!run) begin
      baud_next = 1'b0;
    end else if (cfg_reg.sync) begin
      baud_next = (cfg_reg.src == SBRG_SRC_EXT) ? ext_tick // R16
                                                : div_tick;
    end else begin
      baud_next = div_tick & (os_cnt_reg >= os_last); // R08
    end
  end

  assign sample_next = run & ~cfg_reg.sync & div_tick; // R08

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_tick_reg   <= 1'b0;
      sample_tick_reg <= 1'b0;
    end else begin
      baud_tick_reg   <= baud_next; // R01
      sample_tick_reg <= sample_next;
    end
  end

  // Serial clock out: level is the XOR of a rising and a falling
  // toggle flop, so odd divisors from the master clock split evenly
  assign pos_toggle = run & sck_oe_reg & (cfg_reg.div != 16'h0000) &
                      (div_tick | (src_tick & ~cfg_reg.div[0] &
                                   (cnt_reg == half_mark)));
  assign neg_toggle = run & sck_oe_reg & cfg_reg.div[0] &
                      (cfg_reg.src == SBRG_SRC_MCK) &
                      ((cfg_reg.div == 16'h0001) |
                       (cnt_reg == half_mark)); // R17

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_pos_reg <= 1'b0;
      sck_oe_reg  <= 1'b0;
    end else begin
      sck_pos_reg <= sck_pos_reg ^ pos_toggle;
      sck_oe_reg  <= cfg_reg.clk_out_en & cfg_reg.sync &
                     (cfg_reg.src != SBRG_SRC_EXT);
    end
  end

  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_neg_reg <= 1'b0;
    end else begin
      sck_neg_reg <= sck_neg_reg ^ neg_toggle; // R17
    end
  end

  assign hreadyout   = hreadyout_reg;
  assign hresp       = hresp_reg;
  assign hrdata      = hrdata_reg;
  assign baud_tick   = baud_tick_reg;
  assign sample_tick = sample_tick_reg;
  assign sck_out     = sck_pos_reg ^ sck_neg_reg;
  assign sck_oe      = sck_oe_reg;

  // Checking helpers
  logic [7:0]       gap_cnt_reg;
  logic             gap_valid_reg;
  logic [DIV_W-1:0] wdiv;

  assign wdiv = hwdata[DIV_LSB +: DIV_W];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt_reg   <= 8'h00;
      gap_valid_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      gap_cnt_reg   <= 8'h00;
      gap_valid_reg <= 1'b0;
    end else if (baud_tick_reg) begin
      gap_cnt_reg   <= 8'h00;
      gap_valid_reg <= 1'b1;
    end else if (gap_cnt_reg != 8'hff) begin
      gap_cnt_reg   <= gap_cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  zero_div_a: assert property ( // R04
    cfg_reg.div == 16'h0000 &&
    !(cfg_reg.sync && cfg_reg.src == SBRG_SRC_EXT) |=> !baud_tick_reg)
    else $error("bit tick with zero divisor");

  bypass_a: assert property ( // R05
    run && cfg_reg.div == 16'h0001 && cfg_reg.sync &&
    cfg_reg.src == SBRG_SRC_MCK |=> baud_tick_reg)
    else $error("bypassed divider missed a master clock tick");

  over8_gap_a: assert property ( // R09
    baud_tick_reg && gap_valid_reg && !cfg_reg.sync && cfg_reg.over8
    |-> gap_cnt_reg >= 8'h07)
    else $error("bit ticks closer than eight samples");

  sample_a: assert property ( // R08
    run && !cfg_reg.sync && div_tick |=> sample_tick_reg)
    else $error("divided tick not passed on as sample tick");

  sequence ext_edge_s;
    run && cfg_reg.sync && cfg_reg.src == SBRG_SRC_EXT && ext_tick;
  endsequence

  sync_ext_a: assert property (ext_edge_s |=> baud_tick_reg) // R16
    else $error("pin clock edge not passed undivided");

  freeze_a: assert property ( // R12
    !run |=> $stable(cnt_reg) && $stable(os_cnt_reg) && !baud_tick_reg)
    else $error("generator state moved while gated");

  cfg_write_a: assert property ( // R13
    wr_pend_reg && wr_ofs_reg == DIVCFG_OFS |=> cfg_reg.div == $past(wdiv))
    else $error("divisor write lost");

  frac_off_a: assert property ( // R11
    cfg_reg.sync && src_tick && run && cnt_reg == 16'h0000 &&
    cfg_reg.div > 16'h0001 |=> cnt_reg == $past(cfg_reg.div) - 16'h0001)
    else $error("fraction stretched a synchronous period");

endmodule

/* File: pkg/sbrg_pkg.sv */
// Shared constants, codes and config carrier of the baud rate generator
package sbrg_pkg;

  localparam logic [11:0] MODE_OFS   = 12'h000;
  localparam logic [11:0] DIVCFG_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;

  localparam int unsigned SYNC_BIT   = 0;
  localparam int unsigned OVER_BIT   = 1;
  localparam int unsigned SRC_LSB    = 4;
  localparam int unsigned CLKO_BIT   = 6;
  localparam int unsigned OPM_LSB    = 8;
  localparam int unsigned DIV_LSB    = 0;
  localparam int unsigned FP_LSB     = 16;
  localparam int unsigned ST_RUN_BIT = 16;
  localparam int unsigned ST_OS_LSB  = 20;

  localparam int unsigned DIV_W      = 16;
  localparam int unsigned FP_W       = 3;

  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] DIVCFG_RST = 32'h0000_0000;

  localparam int unsigned PRESC_DIV  = 8;
  localparam logic [3:0]  OVS16_LAST = 4'hf;
  localparam logic [3:0]  OVS8_LAST  = 4'h7;
  localparam logic [3:0]  OPM_NORMAL = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SBRG_SRC_MCK  = 2'h0,
    SBRG_SRC_DIV  = 2'h1,
    SBRG_SRC_RSVD = 2'h2,
    SBRG_SRC_EXT  = 2'h3
  } sbrg_src_t;

  typedef struct packed {
    logic [3:0]       op_mode;
    logic             clk_out_en;
    sbrg_src_t        src;
    logic             over8;
    logic             sync;
    logic [FP_W-1:0]  frac;
    logic [DIV_W-1:0] div;
  } sbrg_cfg_t;

endpackage

/* File: tb/sbrg_ext_clk_src.sv */
// Remote clock source driving the serial clock pin in frames
`timescale 1ns/1ps
module sbrg_ext_clk_src #(
  parameter real HALF = 28.0
)
(
  input  wire logic run,
  output logic      pin
);
  // Seven master periods a cycle; stands low between frames
  initial pin = 1'b0;
  always begin
    #(HALF);
    // Non-blocking, as every pin edge falls on a master clock edge
    pin <= run ? ~pin : 1'b0;
  end
endmodule

/* File: tb/serial_baud_rate_generator_tb_top.sv */
// Self-checking bench of the baud rate generator
`timescale 1ns/1ps
module serial_baud_rate_generator_tb_top
  import sbrg_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        periph_clk_en = 1'b1;
  logic        run = 1'b0;
  logic        hready, hreadyout, hresp, ext_clk_in;
  logic        baud_tick, sample_tick, sck_out, sck_oe;
  logic [31:0] hrdata, q, r, b, s;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_rise = 0;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;
  always @(posedge ext_clk_in) n_rise++;

  sbrg_top #(.PRESC(PRESC_DIV)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .periph_clk_en(periph_clk_en),
    .ext_clk_in(ext_clk_in), .baud_tick(baud_tick),
    .sample_tick(sample_tick), .sck_out(sck_out), .sck_oe(sck_oe)
  );

  sbrg_ext_clk_src u_src (.run(run), .pin(ext_clk_in));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cfg(input logic [31:0] m, dv);
    bus(1'b1, MODE_OFS, m, q);
    bus(1'b1, DIVCFG_OFS, dv, q);
  endtask

  // Counts only enabled edges, so a gated stretch adds nothing
  task automatic gap(input int skip, output logic [31:0] g);
    g = 32'h0;
    repeat (skip) do @(negedge hclk); while (baud_tick !== 1'b1);
    do begin
      @(posedge hclk);
      if (periph_clk_en === 1'b1) g++;
      @(negedge hclk);
    end while (baud_tick !== 1'b1 && g < 32'd4000);
  endtask

  task automatic cnt(input int n);
    b = 32'h0;
    s = 32'h0;
    repeat (n) begin
      @(negedge hclk);
      if (baud_tick === 1'b1) b++;
      if (sample_tick === 1'b1) s++;
    end
  endtask

  task automatic t_regs();
    bus(1'b0, MODE_OFS, 32'h0, q);
    chk("mode reset", q, MODE_RST);
    bus(1'b0, DIVCFG_OFS, 32'h0, q);
    chk("divcfg reset", q, DIVCFG_RST);
    bus(1'b1, DIVCFG_OFS, 32'h0007_ffff, q);
    bus(1'b0, DIVCFG_OFS, 32'h0, q);
    chk("divcfg rw", q, 32'h0007_ffff);
    bus(1'b1, 12'h00c, 32'hffff_ffff, q);
    bus(1'b0, 12'h00c, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_zero();
    cfg(32'h0, 32'h0);
    cnt(100);
    chk("baud div0", b, 32'h0);
    chk("sample div0", s, 32'h0);
    $display("t_zero done");
  endtask

  task automatic t_sync();
    int h;
    h = 0;
    cfg(32'h41, 32'h1);
    gap(2, q);
    chk("sync div1", q, 32'h1);
    chk("sck oe", {31'h0, sck_oe}, 32'h1);
    cfg(32'h41, 32'h3);
    gap(2, q);
    chk("sync div3", q, 32'h3);
    // Sample mid half-cycle so no edge race on the level
    #2;
    repeat (96) begin
      #4;
      if (sck_out === 1'b1) h++;
    end
    chk("sck duty", h, 48);
    $display("t_sync done");
  endtask

  task automatic t_over();
    cfg(32'h0, 32'h2);
    gap(2, q);
    chk("over16", q, 32'd32);
    cnt(64);
    chk("sample rate", s, 32'd32);
    cfg(32'h2, 32'h2);
    gap(2, q);
    chk("over8", q, 32'd16);
    $display("t_over done");
  endtask

  task automatic t_src();
    cfg(32'h12, 32'h1);
    gap(2, q);
    chk("prescaled", q, 8 * PRESC_DIV);
    cfg(32'h20, 32'h1);
    cnt(100);
    chk("reserved src", b, 32'h0);
    $display("t_src done");
  endtask

  task automatic t_frac();
    cfg(32'h2, 32'h0004_0002);
    gap(2, q);
    chk("frac half", q, 32'd20);
    cfg(32'h102, 32'h0004_0002);
    gap(2, q);
    chk("frac other mode", q, 32'd16);
    $display("t_frac done");
  endtask

  task automatic t_gate();
    cfg(32'h2, 32'h1);
    gap(2, q);
    fork
      gap(1, r);
      begin
        do @(negedge hclk); while (baud_tick !== 1'b1);
        @(posedge hclk);
        periph_clk_en <= 1'b0;
        bus(1'b1, MODE_OFS, 32'h42, q);
        bus(1'b0, MODE_OFS, 32'h0, q);
        chk("gated write", q, 32'h42);
        bus(1'b0, STATUS_OFS, 32'h0, q);
        chk("status run", {31'h0, q[ST_RUN_BIT]}, 32'h0);
        periph_clk_en <= 1'b1;
      end
    join
    chk("resume period", r, 32'd8);
    $display("t_gate done");
  endtask

  task automatic t_pin();
    cfg(32'h31, 32'h0);
    @(posedge hclk);
    n_rise = 0;
    run <= 1'b1;
    fork
      cnt(320);
      begin
        repeat (300) @(posedge hclk);
        run <= 1'b0;
      end
    join
    chk("pin ticks", b, n_rise);
    chk("pin seen", {31'h0, n_rise > 0}, 32'h1);
    $display("t_pin done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_zero();
    t_sync();
    t_over();
    t_src();
    t_frac();
    t_gate();
    t_pin();
    tally_and_finish();
  end

  // Whole run needs under two thousand cycles; this is far beyond it
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
